// File: hdl/psba_arbiter.sv
// Secondary bus arbiter with its configuration register port.
// Assumes all inputs synchronous to clk (PCI clock); request pins active low.
`timescale 1ns/10ps
`default_nettype none
`include "psba_defs.svh"

// What this block does
// - Enable bit 0 includes the internal requester in arbitration; resets to 1.
// - Enable bits 1 to 8 include external masters 1 to 8; reset to 1.
// - Read-only bit 9 shows the arbiter select strap; 1 means external arbiter.
// - Timeout enable bit 10 counts 16 idle cycles waiting for frame start.
// - On timeout the waiting master loses its grant.
// - Without refresh, a timed-out master is ignored after releasing its request.
// - With refresh bit 11, broken state clears once all others are served.
// - Field 19:12 loads the fairness counter; cycles grant held against others.
// - Fairness counter reloads on every new grant.
// - Fairness counter starts counting at the first frame start after a grant.
// - Fairness value zero keeps the grant until the owner drops its request.
// - Toggling off keeps the grant asserted through the frame.
// - Toggling on drops the grant one clock after two frame clocks.
// - Bits 22 to 30 give high priority; internal resets high, others low.
module psba_arbiter #(
    parameter int BTO_CYCLES = `PSBA_BTO_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Strap: low selects this arbiter
    input wire logic arbiter_select_strap_n,
    // Bus side, bit 0 is the internal requester
    input wire logic [`PSBA_NREQ-1:0] req_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    output logic [`PSBA_NREQ-1:0] gnt_n,
    // Configuration access
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack
);
    localparam int CW = $clog2(BTO_CYCLES + 1);
    localparam logic [CW-1:0] BTO_LAST = CW'(BTO_CYCLES - 1);

    // Elaboration check on the timeout length
    if (BTO_CYCLES < 1) begin : g_bad_bto
        $error("BTO_CYCLES must be at least 1");
    end

    psba_pkg::psba_state_t st_r, st_nxt;
    psba_pkg::psba_vec_t en_r, prio_r, broken_r, ignore_r, served_r, cand, hi, pick_mask;
    logic bto_en_r, refresh_r, tog_en_r, strap_ext_r, strap_done_r;
    logic [7:0] fair_cfg_r, fair_cnt_r;
    logic fair_armed_r;
    logic [CW-1:0] bto_cnt_r;
    logic [1:0] tog_cnt_r;
    logic [3:0] owner_r, owner_nxt;
    logic frame_n_d_r, frame_fall, bus_idle, own_req, others_req;
    logic new_grant, bto_fire, granted_nxt, drop_nxt;
    logic [31:0] arb_word;

    // Round robin search after the last owner
    function automatic logic [3:0] rr_pick(input psba_pkg::psba_vec_t m, input logic [3:0] last);
        int j;
        logic [3:0] sel;
        logic found;
        sel = last;
        found = 1'b0;
        for (int k = 1; k <= `PSBA_NREQ; k++) begin
            j = (int'(last) + k) % `PSBA_NREQ;
            if (!found && m[j]) begin
                sel = 4'(j);
                found = 1'b1;
            end
        end
        return sel;
    endfunction

    // One-hot of a requester index
    function automatic psba_pkg::psba_vec_t onehot(input logic [3:0] idx);
        psba_pkg::psba_vec_t v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    // Bus observation
    assign frame_fall = frame_n_d_r & ~frame_n;
    assign bus_idle = frame_n & irdy_n;
    assign own_req = ~req_n[owner_r] & en_r[owner_r] & ~strap_ext_r;
    assign others_req = |(~req_n & en_r & ~onehot(owner_r));
    assign cand = ~req_n & en_r & ~ignore_r;
    assign hi = cand & prio_r;
    assign pick_mask = (|hi) ? hi : cand;

    // Grant sequencing
    always_comb begin
        st_nxt = st_r;
        owner_nxt = owner_r;
        new_grant = 1'b0;
        bto_fire = 1'b0;
        unique case (st_r)
            psba_pkg::ST_IDLE: begin
                if (strap_done_r && !strap_ext_r && |cand) begin
                    owner_nxt = rr_pick(pick_mask, owner_r);
                    st_nxt = psba_pkg::ST_WAIT;
                    new_grant = 1'b1;
                end
            end
            psba_pkg::ST_WAIT: begin
                if (!own_req) begin
                    st_nxt = psba_pkg::ST_GAP;
                end else if (frame_fall) begin
                    st_nxt = psba_pkg::ST_XFER;
                end else if (bto_en_r && bus_idle && bto_cnt_r == BTO_LAST) begin
                    bto_fire = 1'b1;
                    st_nxt = psba_pkg::ST_GAP;
                end
            end
            psba_pkg::ST_XFER: begin
                if (!own_req) begin
                    st_nxt = psba_pkg::ST_GAP;
                end else if (fair_cfg_r != 8'h00 && fair_armed_r && fair_cnt_r == 8'h00
                             && others_req) begin
                    st_nxt = psba_pkg::ST_GAP;
                end
            end
            psba_pkg::ST_GAP: st_nxt = psba_pkg::ST_IDLE;
        endcase
    end

    assign granted_nxt = (st_nxt == psba_pkg::ST_WAIT) || (st_nxt == psba_pkg::ST_XFER);
    assign drop_nxt = tog_en_r && (tog_cnt_r == `PSBA_TOG_HOLD);

    // State and owner
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= psba_pkg::ST_IDLE;
            owner_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            owner_r <= owner_nxt;
        end
    end

    // Grant pins, one flop per pin, active low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gnt_n <= '1;
        end else if (granted_nxt && !drop_nxt) begin
            gnt_n <= ~onehot(owner_nxt);
        end else begin
            gnt_n <= '1;
        end
    end

    // Frame edge detector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frame_n_d_r <= 1'b1;
        end else begin
            frame_n_d_r <= frame_n;
        end
    end

    // Strap capture once after reset release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_ext_r <= 1'b1;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_ext_r <= arbiter_select_strap_n;
            strap_done_r <= 1'b1;
        end
    end

    // Broken master idle counter
    always_ff @(posedge clk) begin
        if (sys_rst || new_grant) begin
            bto_cnt_r <= '0;
        end else if (st_r == psba_pkg::ST_WAIT && bus_idle && bto_en_r
                     && bto_cnt_r != BTO_LAST) begin
            bto_cnt_r <= bto_cnt_r + CW'(1);
        end
    end

    // Fairness counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fair_cnt_r <= `PSBA_FAIR_RST;
            fair_armed_r <= 1'b0;
        end else if (new_grant) begin
            fair_cnt_r <= fair_cfg_r;
            fair_armed_r <= 1'b0;
        end else begin
            if (frame_fall && st_r == psba_pkg::ST_WAIT) begin
                fair_armed_r <= 1'b1;
            end
            if (fair_armed_r && others_req && fair_cnt_r != 8'h00) begin
                fair_cnt_r <= fair_cnt_r - 8'h01;
            end
        end
    end

    // Frame clocks seen by the owner for grant toggling
    always_ff @(posedge clk) begin
        if (sys_rst || new_grant) begin
            tog_cnt_r <= 2'h0;
        end else if (tog_cnt_r == `PSBA_TOG_HOLD) begin
            tog_cnt_r <= `PSBA_TOG_DONE;
        end else if ((st_r == psba_pkg::ST_WAIT || st_r == psba_pkg::ST_XFER) && !frame_n
                     && tog_cnt_r != `PSBA_TOG_DONE) begin
            tog_cnt_r <= tog_cnt_r + 2'h1;
        end
    end

    // Broken, ignored and served bookkeeping
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            broken_r <= '0;
            ignore_r <= '0;
            served_r <= '0;
        end else if (refresh_r && |ignore_r && &(served_r | ignore_r | ~en_r)) begin
            // A timeout in the refresh cycle still marks its master
            broken_r <= bto_fire ? onehot(owner_r) : '0;
            ignore_r <= '0;
            served_r <= '0;
        end else begin
            if (bto_fire) begin
                broken_r <= broken_r | onehot(owner_r);
            end
            ignore_r <= ignore_r | (broken_r & req_n);
            if (new_grant) begin
                served_r <= served_r | onehot(owner_nxt);
            end
        end
    end

    // Arbiter word as read back
    always_comb begin
        arb_word = 32'h0000_0000;
        arb_word[`PSBA_EN_MSB:`PSBA_EN_LSB] = en_r;
        arb_word[`PSBA_STRAP_BIT] = strap_ext_r;
        arb_word[`PSBA_BTO_BIT] = bto_en_r;
        arb_word[`PSBA_REFRESH_BIT] = refresh_r;
        arb_word[`PSBA_FAIR_MSB:`PSBA_FAIR_LSB] = fair_cfg_r;
        arb_word[`PSBA_TOG_BIT] = tog_en_r;
        arb_word[`PSBA_PRIO_MSB:`PSBA_PRIO_LSB] = prio_r;
    end

    // Configuration writes with byte enables
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_r <= `PSBA_EN_RST;
            bto_en_r <= 1'b0;
            refresh_r <= 1'b0;
            fair_cfg_r <= `PSBA_FAIR_RST;
            tog_en_r <= 1'b0;
            prio_r <= `PSBA_PRIO_RST;
        end else if (cfg_wr && cfg_addr == `PSBA_OFS_ARB) begin
            if (cfg_be[0]) begin
                en_r[7:0] <= cfg_wdata[7:0];
            end
            if (cfg_be[1]) begin
                en_r[8] <= cfg_wdata[`PSBA_EN_MSB];
                bto_en_r <= cfg_wdata[`PSBA_BTO_BIT];
                refresh_r <= cfg_wdata[`PSBA_REFRESH_BIT];
                fair_cfg_r[3:0] <= cfg_wdata[15:12];
            end
            if (cfg_be[2]) begin
                fair_cfg_r[7:4] <= cfg_wdata[`PSBA_FAIR_MSB:16];
                tog_en_r <= cfg_wdata[`PSBA_TOG_BIT];
                prio_r[1:0] <= cfg_wdata[23:`PSBA_PRIO_LSB];
            end
            if (cfg_be[3]) begin
                prio_r[8:2] <= cfg_wdata[`PSBA_PRIO_MSB:24];
            end
        end
    end

    // Configuration reads, one cycle answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= cfg_rd | cfg_wr;
            if (cfg_rd) begin
                cfg_rdata <= (cfg_addr == `PSBA_OFS_ARB) ? arb_word : 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/psba_defs.svh
// Constants for the secondary bus arbiter: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the arbiter package and module.
`ifndef PSBA_DEFS_SVH
`define PSBA_DEFS_SVH

`define PSBA_NREQ 9
`define PSBA_OFS_RSVD 8'h44
`define PSBA_OFS_ARB 8'h48
`define PSBA_EN_LSB 0
`define PSBA_EN_MSB 8
`define PSBA_EN_RST 9'h1ff
`define PSBA_STRAP_BIT 9
`define PSBA_BTO_BIT 10
`define PSBA_REFRESH_BIT 11
`define PSBA_FAIR_LSB 12
`define PSBA_FAIR_MSB 19
`define PSBA_FAIR_RST 8'h08
`define PSBA_TOG_BIT 20
`define PSBA_PRIO_LSB 22
`define PSBA_PRIO_MSB 30
`define PSBA_PRIO_RST 9'h001
`define PSBA_BTO_CYCLES 16
`define PSBA_TOG_HOLD 2'h2
`define PSBA_TOG_DONE 2'h3

`endif

// File: hdl/psba_pkg.sv
// Types shared by the secondary bus arbiter.
// Assumes psba_defs.svh is on the include path.
`include "psba_defs.svh"

package psba_pkg;
    // Grant sequencing states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_XFER,
        ST_GAP
    } psba_state_t;
    typedef logic [`PSBA_NREQ-1:0] psba_vec_t;
endpackage

// File: dv/psba_arbiter_monitor.sv
// Checker for the secondary bus arbiter, watching only its ports.
// Assumes one clock domain and a bind onto every arbiter instance.
`timescale 1ns/10ps
`default_nettype none
module psba_arbiter_monitor #(
    parameter int BTO_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus side
    input wire logic arbiter_select_strap_n,
    input wire logic [8:0] req_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic [8:0] gnt_n,
    // Configuration access
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack
);
    logic [8:0] en_sh, g_q;
    logic bto_sh, tog_sh, seen_fr;
    int idle_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the controls the checks depend on
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_sh <= 9'h1ff;
            bto_sh <= 1'b0;
            tog_sh <= 1'b0;
        end else if (cfg_wr && cfg_addr == 8'h48) begin
            if (cfg_be[0]) en_sh[7:0] <= cfg_wdata[7:0];
            if (cfg_be[1]) en_sh[8] <= cfg_wdata[8];
            if (cfg_be[1]) bto_sh <= cfg_wdata[10];
            if (cfg_be[2]) tog_sh <= cfg_wdata[20];
        end
    end
    // Idle samples under one grant before any frame starts
    always_ff @(posedge clk) begin
        g_q <= gnt_n;
        if (sys_rst || gnt_n == 9'h1ff || gnt_n != g_q) begin
            idle_cnt <= 0;
            seen_fr <= 1'b0;
        end else if (!frame_n) seen_fr <= 1'b1;
        else if (irdy_n && !seen_fr) idle_cnt <= idle_cnt + 1;
    end
    a_grant_one_hot: assert property ($onehot0(~gnt_n))
        else $error("several grants low");
    a_disabled_no_grant: assert property (((~gnt_n) & g_q & ~$past(en_sh)) == 9'h0)
        else $error("grant to disabled requester");
    a_strap_no_grant: assert property (arbiter_select_strap_n |-> gnt_n == 9'h1ff)
        else $error("grant with external arbiter");
    a_strap_readback: assert property (cfg_rd && cfg_addr == 8'h48 |=>
        cfg_ack && cfg_rdata[9] == arbiter_select_strap_n) else $error("strap bit wrong");
    a_bto_bound: assert property (bto_sh |-> idle_cnt <= BTO_CYCLES + 1)
        else $error("grant outlived timeout");
    a_owner_drop: assert property ((~gnt_n & req_n) != 9'h0 |=> gnt_n == 9'h1ff)
        else $error("grant kept after request dropped");
    a_no_toggle_hold: assert property (!tog_sh && !frame_n && gnt_n != 9'h1ff &&
        req_n == gnt_n |=> gnt_n == $past(gnt_n)) else $error("grant lost in frame");
    a_toggle_gap: assert property (tog_sh && !frame_n && !$past(frame_n) &&
        gnt_n != 9'h1ff && req_n == gnt_n |-> ##[0:2] gnt_n == 9'h1ff ##1 gnt_n != 9'h1ff)
        else $error("toggle gap wrong");
    c_last_master: cover property (!gnt_n[8]);
    c_timeout: cover property (bto_sh && idle_cnt == BTO_CYCLES - 1 ##1 gnt_n == 9'h1ff);
    c_toggle: cover property (tog_sh && !frame_n && gnt_n == 9'h1ff);
endmodule
bind psba_arbiter psba_arbiter_monitor #(.BTO_CYCLES(BTO_CYCLES)) i_psba_arbiter_monitor (
    .clk(clk), .sys_rst(sys_rst), .arbiter_select_strap_n(arbiter_select_strap_n),
    .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n), .gnt_n(gnt_n), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
`default_nettype wire

// File: dv/psba_master_model.sv
// Behavioural bus masters answering the arbiter grants.
// Assumes bench controls change just after the clock edge; bus lines pulled up.
`timescale 1ns/10ps
`default_nettype none
module psba_master_model (
    // Clock, reset and bench control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [8:0] want,
    input wire logic [8:0] stall,
    input wire logic [8:0] hog,
    // Bus side
    input wire logic [8:0] gnt_n,
    output logic [8:0] req_n,
    output logic frame_n,
    output logic irdy_n
);
    int beat;
    int own;
    // Granted master starts a two-clock frame once the bus is idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            beat <= 0;
            frame_n <= 1'b1;
            irdy_n <= 1'b1;
        end else if (beat == 0) begin
            for (int i = 0; i < 9; i++) begin
                if (!gnt_n[i] && !req_n[i] && !stall[i] && frame_n && irdy_n) begin
                    own <= i;
                    beat <= 1;
                    frame_n <= 1'b0;
                    irdy_n <= 1'b0;
                end
            end
        end else begin
            beat <= (beat + 1) % 8;
            frame_n <= beat >= 2;
            irdy_n <= beat >= 3;
        end
    end
    // Requests; a non-hog owner releases for one clock after its transfer
    always_ff @(posedge clk) begin
        for (int i = 0; i < 9; i++) begin
            req_n[i] <= sys_rst || !want[i] || (beat == 6 && own == i && !hog[i]);
        end
    end
endmodule
`default_nettype wire

// File: dv/pci_secondary_bus_arbiter_tb_top.sv
// Self-checking bench for the secondary bus arbiter.
// Assumes the design, checker and master model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module pci_secondary_bus_arbiter_tb_top;
    logic clk, sys_rst, strap_n, cfg_rd, cfg_wr, frame_n, irdy_n, cfg_ack;
    logic [8:0] req_n, gnt_n, want, stall, hog, served, en;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be, be;
    logic [31:0] cfg_wdata, cfg_rdata, shadow, wd;
    int miscompares, checks_done, n;
    psba_arbiter #(.BTO_CYCLES(4)) i_psba_arbiter (.clk(clk), .sys_rst(sys_rst),
        .arbiter_select_strap_n(strap_n), .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n),
        .gnt_n(gnt_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    psba_master_model i_psba_master_model (.clk(clk), .sys_rst(sys_rst), .want(want),
        .stall(stall), .hog(hog), .gnt_n(gnt_n), .req_n(req_n), .frame_n(frame_n),
        .irdy_n(irdy_n));
    // Clock and record of granted requesters
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) served <= served | ~gnt_n;
    task automatic conclude();
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // One strobe cycle, then the acknowledge cycle
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, b, d};
        cycles(1);
        check(32'(cfg_ack), 32'h1);
        {cfg_wr, cfg_rd} = 2'b00;
        cycles(1);
    endtask
    function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] b);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h7fdffdff;
        return (o & ~m) | (d & m);
    endfunction
    task automatic restart(input logic s);
        {sys_rst, strap_n, want, stall, hog} = {1'b1, s, 27'h0};
        cycles(3);
        sys_rst = 1'b0;
        cycles(1);
    endtask
    // Hang guard
    initial begin
        #300000;
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(32'hd78a4de4));
        {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata, miscompares, checks_done} = '0;
        restart(1'b0);
        cfg(1'b0, 8'h44, 4'h0, 32'h0);
        check(cfg_rdata, 32'h0);
        shadow = 32'h004081ff;
        cfg(1'b0, 8'h48, 4'h0, 32'h0);
        check(cfg_rdata, shadow);
        // Random byte-lane writes, all-ones corner first
        for (int i = 0; i < 7; i++) begin
            wd = (i == 0) ? 32'hffffffff : $urandom;
            be = (i == 0) ? 4'hf : 4'($urandom);
            cfg(1'b1, 8'h48, be, wd);
            shadow = merge(shadow, wd, be);
            cfg(1'b0, 8'h48, 4'h0, 32'h0);
            check(cfg_rdata, shadow);
        end
        // Only enabled requesters are served
        for (int i = 0; i < 3; i++) begin
            en = (i == 0) ? 9'h1ff : 9'($urandom);
            cfg(1'b1, 8'h48, 4'hf, 32'h00008000 | 32'(en));
            {want, served} = {9'h1ff, 9'h0};
            cycles(150);
            check(32'(served), 32'(en));
            want = 9'h0;
            cycles(10);
        end
        // Broken master timeout, then ignored
        cfg(1'b1, 8'h48, 4'hf, 32'h000085ff);
        {want, stall} = {9'h008, 9'h008};
        cycles(2);
        check(32'(gnt_n[3]), 32'h0);
        for (n = 0; !gnt_n[3] && n < 20; n++) cycles(1);
        check(32'(n inside {[3:6]}), 32'h1);
        want = 9'h0;
        cycles(2);
        {stall, want, served} = {9'h0, 9'h008, 9'h0};
        cycles(30);
        check(32'(served[3]), 32'h0);
        cfg(1'b1, 8'h48, 4'hf, 32'h00008c0e);
        want = 9'h00e;
        cycles(100);
        check(32'(served[3]), 32'h1);
        // Grant toggling during frames: gap on the third edge after frame start
        want = 9'h0;
        cycles(12);
        cfg(1'b1, 8'h48, 4'hf, 32'h00108002);
        want = 9'h002;
        for (n = 0; frame_n && n < 20; n++) cycles(1);
        cycles(3);
        check(32'(gnt_n[1]), 32'h1);
        cycles(1);
        check(32'(gnt_n[1]), 32'h0);
        cycles(25);
        want = 9'h0;
        cycles(10);
        // Fairness zero keeps the hog, nonzero passes the bus on
        cfg(1'b1, 8'h48, 4'hf, 32'h00000006);
        {hog, want} = {9'h002, 9'h002};
        cycles(3);
        {want, served} = {9'h006, 9'h0};
        cycles(60);
        check(32'(served[2]), 32'h0);
        hog = 9'h0;
        cfg(1'b1, 8'h48, 4'hf, 32'h00004006);
        cycles(20);
        {hog, served} = {9'h002, 9'h0};
        cycles(60);
        check(32'(served[2]), 32'h1);
        // External arbiter strap
        restart(1'b1);
        cfg(1'b0, 8'h48, 4'h0, 32'h0);
        check(cfg_rdata, 32'h004083ff);
        {want, served} = {9'h1ff, 9'h0};
        cycles(40);
        check(32'(served), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
